//--- core/stx_tx.sv
`timescale 1ns/100ps
`include "stx_consts.svh"
module stx_tx
#(
   parameter int FIFO_DEPTH = `STX_FIFO_DEPTH
)
(
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire stx_pkg::stx_char_s wr_char,
   input  wire logic               wr_valid,
   output      logic               wr_ready,
   input  wire logic               load_enable_immediate,
   input  wire logic               load_enable_next,
   input  wire logic               mode_above_mid,
   input  wire logic               mode_below_mid,
   input  wire logic               self_test_enable_low,
   input  wire logic               optical_output_disable,
   output      logic               read_strobe_out,
   output      logic               byte_write_clock,
   output      stx_pkg::stx_pair_s serial_out_pair_first,
   output      stx_pkg::stx_pair_s serial_out_pair_second,
   output      stx_pkg::stx_pair_s serial_out_pair_diag
);
   import stx_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   wire  [5:0] pin_raw = {load_enable_immediate, load_enable_next,
                          mode_above_mid, mode_below_mid,
                          self_test_enable_low, optical_output_disable};

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= `STX_PIN_RST;
         pin_sync <= `STX_PIN_RST;
      end
      else
      begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   wire       ena_s    = pin_sync[5];
   wire       enn_s    = pin_sync[4];
   wire       above_s  = pin_sync[3];
   wire       below_s  = pin_sync[2];
   wire       stest_s  = pin_sync[1];
   wire       opt_s    = pin_sync[0];
   wire       en_any   = !ena_s || !enn_s;

   // mid level (neither comparator) is factory test mode
   stx_mode_e mode;
   assign mode = above_s ? STX_BYP : (below_s ? STX_ENC : STX_TEST);

   // ------------------------------------------------------------
   // divide-by-ten bit counter
   // ------------------------------------------------------------
   // sys_clk is the bit clock; the byte rate is one tick per ten bits
   logic [3:0] bit_cnt;
   wire        tick         = bit_cnt == `STX_LAST_BIT;
   wire  [3:0] next_bit_cnt = tick ? `STX_FIRST_BIT
                                   : 4'(bit_cnt + 1'b1);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         bit_cnt <= `STX_FIRST_BIT;
      else
         bit_cnt <= next_bit_cnt;
   end

   // ------------------------------------------------------------
   // self-test sequencer
   // ------------------------------------------------------------
   stx_bist_e  bist_st;
   stx_bist_e  next_bist;
   logic [8:0] lfsr;
   wire        bist_on    = bist_st != STX_B_OFF;
   wire        bist_run   = bist_st == STX_B_RUN;
   wire        bist_exit  = stest_s && !en_any;
   wire        loop_start = lfsr == `STX_LFSR_SEED;

   always_comb
   begin
      unique case (bist_st)
         STX_B_OFF: next_bist = !stest_s ? STX_B_ALT : STX_B_OFF;
         STX_B_ALT: next_bist = bist_exit ? STX_B_OFF :
                                en_any ? STX_B_RUN : STX_B_ALT;
         STX_B_RUN: next_bist = bist_exit ? STX_B_OFF : STX_B_RUN;
         default:   next_bist = STX_B_OFF;
      endcase
   end

   // nine-bit maximal sequence: 511 characters per loop, every byte
   // as a special and all but 01 as data, so the undefined specials appear
   wire [8:0] next_lfsr = (bist_st == STX_B_ALT) ? `STX_LFSR_SEED
                        : {lfsr[7:0], lfsr[8] ^ lfsr[4]};
   // the seed state sends the loop-start data character instead
   stx_char_s bist_ch;
   assign bist_ch = loop_start ? stx_char_s'({2'b00, `STX_LOOP_BYTE})
                               : stx_char_s'({lfsr[8], 1'b0, lfsr[7:0]});

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bist_st <= STX_B_OFF;
         lfsr    <= `STX_LFSR_SEED;
      end
      else if (tick)
      begin
         bist_st <= next_bist;
         lfsr    <= next_lfsr;
      end
   end

   // ------------------------------------------------------------
   // input buffer and input register
   // ------------------------------------------------------------
   logic [`STX_CHAR_W-1:0] fifo_data;
   logic                   fifo_valid;
   wire                    pop = tick && en_any && !bist_on && fifo_valid;

   stx_fifo #(
      .WIDTH (`STX_CHAR_W),
      .DEPTH (FIFO_DEPTH)
   ) stx_fifo_inst (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_char),
      .out_valid (fifo_valid),
      .out_ready (pop),
      .out_data  (fifo_data)
   );

   stx_char_s in_reg;
   logic      in_pad;
   stx_char_s pad_ch;
   assign pad_ch = stx_char_s'({2'b10, `STX_PAD_BYTE});

   // an empty buffer also yields a pad, keeping the line framed
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_reg <= stx_char_s'({2'b10, `STX_PAD_BYTE});
         in_pad <= 1'b1;
      end
      else if (tick)
      begin
         in_reg <= pop ? stx_char_s'(fifo_data) : pad_ch;
         in_pad <= !pop;
      end
   end

   // ------------------------------------------------------------
   // encoder and shifter
   // ------------------------------------------------------------
   logic       rd;
   logic [9:0] enc_code;
   logic       enc_rd;
   logic [9:0] shifter;
   stx_char_s  enc_ch;
   assign enc_ch = bist_on ? bist_ch : in_reg;

   stx_enc stx_enc_inst (
      .ch     (enc_ch),
      .rd_in  (rd),
      .code   (enc_code),
      .rd_out (enc_rd)
   );

   // raw character: a = special select, b..i = data 0..7, j = violation
   wire [7:0] raw_data = {<<{in_reg.data}};
   wire [9:0] raw_code = {in_reg.sc, raw_data, in_reg.fv};
   wire       bypass   = (mode == STX_BYP) && !bist_on && !in_pad;
   wire       alt      = bist_st == STX_B_ALT;
   wire [9:0] load_code = alt ? `STX_ALT_CODE
                        : bypass ? raw_code : enc_code;
   // disparity only follows encoded characters, so the first pad
   // after raw bypass data may start on the wrong sense
   wire       next_rd  = (bypass || alt) ? rd : enc_rd;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shifter <= `STX_ALT_CODE;
         rd      <= 1'b0;
      end
      else if (tick)
      begin
         shifter <= load_code;
         rd      <= next_rd;
      end
      else
         shifter <= {shifter[8:0], 1'b0};
   end

   // ------------------------------------------------------------
   // read strobe and byte clock
   // ------------------------------------------------------------
   logic strobe_en;
   wire  tick_strobe     = bist_run ? loop_start : (!bist_on && !ena_s);
   wire  next_strobe_en  = tick ? tick_strobe : strobe_en;
   wire  next_strobe     = !(next_strobe_en
                             && next_bit_cnt < `STX_STROBE_LOW);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strobe_en        <= 1'b0;
         read_strobe_out  <= 1'b1;
         byte_write_clock <= 1'b0;
      end
      else
      begin
         strobe_en        <= next_strobe_en;
         read_strobe_out  <= next_strobe;
         byte_write_clock <= next_bit_cnt < `STX_CLK_HIGH;
      end
   end

   // ------------------------------------------------------------
   // serial outputs
   // ------------------------------------------------------------
   // in test mode pair A/B is the tester's clock input, so hold it low
   wire line_bit = shifter[9];
   wire ab_off   = opt_s || (mode == STX_TEST);
   wire ab_bit   = line_bit && !ab_off;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_out_pair_first  <= stx_pair_s'(2'b01);
         serial_out_pair_second <= stx_pair_s'(2'b01);
         serial_out_pair_diag   <= stx_pair_s'(2'b01);
      end
      else
      begin
         serial_out_pair_first  <= {ab_bit, !ab_bit};
         serial_out_pair_second <= {ab_bit, !ab_bit};
         serial_out_pair_diag   <= {line_bit, !line_bit};
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   property p_frame;
      tick |=> (bit_cnt == `STX_FIRST_BIT) ##9 tick;
   endproperty
   a_frame: assert property (p_frame)
      else $error("character frame is not ten bits");

   property p_ten;
      tick |=> !tick [*8] ##1 !tick ##1 tick;
   endproperty
   a_ten: assert property (p_ten)
      else $error("byte tick not every tenth bit");

   property p_capture;
      pop |=> in_reg == $past(fifo_data) && !in_pad;
   endproperty
   a_capture: assert property (p_capture)
      else $error("input register missed the character");

   property p_gate;
      (tick && !en_any && fifo_valid)
         |=> fifo_valid && fifo_data == $past(fifo_data);
   endproperty
   a_gate: assert property (p_gate)
      else $error("character taken while loading disabled");

   property p_pad;
      (tick && !en_any) |=> in_pad && in_reg.data == `STX_PAD_BYTE;
   endproperty
   a_pad: assert property (p_pad)
      else $error("pad not inserted with enables high");

   property p_shift;
      !tick |=> shifter[9] == $past(shifter[8]);
   endproperty
   a_shift: assert property (p_shift)
      else $error("shifter did not advance one bit");

   property p_viol;
      (tick && !bist_on && !bypass && in_reg.fv)
         |=> shifter == `STX_VIOL_CODE;
   endproperty
   a_viol: assert property (p_viol)
      else $error("forced violation not sent");

   property p_bypass;
      (tick && bypass) |=> shifter == $past(raw_code);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass character altered");

   property p_alt;
      (tick && alt) |=> shifter == `STX_ALT_CODE;
   endproperty
   a_alt: assert property (p_alt)
      else $error("self-test alternating pattern missing");

   property p_same;
      !ab_off |=> serial_out_pair_first == serial_out_pair_diag
               && serial_out_pair_second == serial_out_pair_diag;
   endproperty
   a_same: assert property (p_same)
      else $error("serial pairs differ");

   property p_optical;
      opt_s |=> !serial_out_pair_first.p && serial_out_pair_first.n
             && !serial_out_pair_second.p && serial_out_pair_second.n;
   endproperty
   a_optical: assert property (p_optical)
      else $error("optical disable did not hold pairs low");

   property p_strobe;
      (tick && tick_strobe) |=> !read_strobe_out [*6] ##1 read_strobe_out;
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("read strobe not low six bits");

   c_pad: cover property (tick && in_pad && !bist_on);
   c_bypass: cover property (tick && bypass);
   c_loop: cover property (tick && bist_run && loop_start);
   c_full: cover property (!wr_ready);
endmodule : stx_tx

//--- core/stx_consts.svh
`ifndef STX_CONSTS_SVH
`define STX_CONSTS_SVH
`define STX_CHAR_W      10
`define STX_FIFO_DEPTH  16
`define STX_LAST_BIT    4'h9
`define STX_FIRST_BIT   4'h0
`define STX_STROBE_LOW  4'h6
`define STX_CLK_HIGH    4'h5
`define STX_PAD_BYTE    8'h05
`define STX_LOOP_BYTE   8'h00
`define STX_VIOL_CODE   10'h3F0
`define STX_ALT_CODE    10'h2AA
`define STX_LFSR_SEED   9'h001
`define STX_PIN_RST     6'h36
`define STX_K_COUNT     4'hC
`define STX_K28_COUNT   4'h8
`define STX_K28_6B      6'h0F
`endif

//--- core/stx_pkg.sv
package stx_pkg;
   typedef struct packed
   {
      logic       sc;
      logic       fv;
      logic [7:0] data;
   } stx_char_s;

   typedef struct packed
   {
      logic p;
      logic n;
   } stx_pair_s;

   typedef enum logic [1:0]
   {
      STX_ENC  = 2'b00,
      STX_BYP  = 2'b01,
      STX_TEST = 2'b10
   } stx_mode_e;

   typedef enum logic [1:0]
   {
      STX_B_OFF = 2'b00,
      STX_B_ALT = 2'b01,
      STX_B_RUN = 2'b10
   } stx_bist_e;
endpackage : stx_pkg

//--- core/stx_fifo.sv
`timescale 1ns/100ps
module stx_fifo
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
)
(
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
         if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
         count <= (AW+1)'(count + push - pop);
      end
   end
endmodule : stx_fifo

//--- core/stx_enc.sv
`timescale 1ns/100ps
`include "stx_consts.svh"
module stx_enc
(
   input  wire stx_pkg::stx_char_s ch,
   input  wire logic               rd_in,
   output      logic [9:0]         code,
   output      logic               rd_out
);
   import stx_pkg::*;

   // negative-disparity forms, bit a leftmost
   function automatic logic [5:0] stx_6b(input logic [4:0] x);
      logic [5:0] t [32];
      t = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
            6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
            6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
            6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
      return t[x];
   endfunction : stx_6b

   function automatic logic [3:0] stx_4b(input logic [2:0] y,
                                         input logic       k28);
      logic [3:0] d [8];
      logic [3:0] k [8];
      d = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
      k = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};
      return k28 ? k[y] : d[y];
   endfunction : stx_4b

   // special codes: C0.0..C7.0 are K28.y, C8.0..C11.0 the other K.7
   wire [3:0] kidx     = ch.data[3:0];
   wire       kvalid   = (ch.data[7:4] == 4'h0) && (kidx < `STX_K_COUNT);
   wire       k28      = ch.sc && (kidx < `STX_K28_COUNT);
   wire [4:0] kx_hi    = (kidx == 4'h8) ? 5'd23 : (kidx == 4'h9) ? 5'd27 :
                         (kidx == 4'hA) ? 5'd29 : 5'd30;
   wire [4:0] x        = !ch.sc ? ch.data[4:0] : k28 ? 5'd28 : kx_hi;
   wire [2:0] y        = !ch.sc ? ch.data[7:5] : k28 ? kidx[2:0] : 3'd7;
   wire       viol     = ch.fv || (ch.sc && !kvalid);
   wire [5:0] c6m      = k28 ? `STX_K28_6B : stx_6b(x);
   wire       inv6     = ($countones(c6m) != 3) || (c6m == 6'h38);
   wire [5:0] c6       = (rd_in && inv6) ? ~c6m : c6m;
   wire       rd6      = rd_in ^ ($countones(c6) != 3);
   wire       alt7     = (!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
                      || (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14));
   wire       a7       = !k28 && (y == 3'd7) && (ch.sc || alt7);
   wire [3:0] c4m      = a7 ? 4'h7 : stx_4b(y, k28);
   wire       inv4     = ($countones(c4m) != 2) || (c4m == 4'hC);
   wire [3:0] c4       = k28 ? (rd_in ? ~c4m : c4m)
                             : ((rd6 && inv4) ? ~c4m : c4m);

   assign code   = viol ? `STX_VIOL_CODE : {c6, c4};
   assign rd_out = rd_in ^ ($countones(code) != 5);
endmodule : stx_enc

//--- tb/stx_host_model.sv
`timescale 1ns/100ps
module stx_host_model
(
   input  wire logic               sys_clk,
   input  wire logic               wr_ready,
   output      stx_pkg::stx_char_s wr_char,
   output      logic               wr_valid
);
   import stx_pkg::*;
   stx_char_s q[$];
   int        gap = 0;
   int        idle = 0;
   logic      taken = 1'b0;
   initial
   begin
      wr_char  = '0;
      wr_valid = 1'b0;
   end
   task automatic send(input stx_char_s ch);
      q.push_back(ch);
   endtask : send
   always @(posedge sys_clk)
      taken <= wr_valid & wr_ready;
   // one word at a time, held until taken; an idle bus toggles so
   // stale data can never look valid
   always @(negedge sys_clk)
   begin
      if (taken)
      begin
         void'(q.pop_front());
         idle = gap;
      end
      if (q.size() != 0 && idle == 0)
      begin
         wr_char  = q[0];
         wr_valid = 1'b1;
      end
      else
      begin
         if (idle != 0)
            idle--;
         wr_char  = ~wr_char;
         wr_valid = 1'b0;
      end
   end
endmodule : stx_host_model

//--- tb/serial_link_tx_8b10b_tb_top.sv
`timescale 1ns/100ps
module serial_link_tx_8b10b_tb_top;
   import stx_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rst_n = 1'b0;
   stx_char_s  wr_char;
   logic       wr_valid;
   logic       wr_ready;
   logic       load_enable_immediate = 1'b1;
   logic       load_enable_next = 1'b1;
   logic       mode_above_mid = 1'b0;
   logic       mode_below_mid = 1'b1;
   logic       self_test_enable_low = 1'b1;
   logic       optical_output_disable = 1'b0;
   logic       read_strobe_out;
   logic       byte_write_clock;
   stx_pair_s  serial_out_pair_first;
   stx_pair_s  serial_out_pair_second;
   stx_pair_s  serial_out_pair_diag;
   int         num_errors = 0;
   int         comparisons = 0;
   int         cyc = 0;
   int         lows = 0;
   int         highs = 0;
   logic [9:0] fr[$];
   logic [9:0] ex[$];
   stx_char_s  c;
   stx_tx #(.FIFO_DEPTH(16)) stx_tx_inst
   (
      .sys_clk, .rst_n, .wr_char, .wr_valid, .wr_ready,
      .load_enable_immediate, .load_enable_next, .mode_above_mid,
      .mode_below_mid, .self_test_enable_low, .optical_output_disable,
      .read_strobe_out, .byte_write_clock, .serial_out_pair_first,
      .serial_out_pair_second, .serial_out_pair_diag
   );
   stx_host_model stx_host_model_inst
   (
      .sys_clk, .wr_ready, .wr_char, .wr_valid
   );
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end
   // mirrors the bit counter: bit a of a frame shows after edge 10m+1
   always @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         cyc <= 0;
      else
         cyc <= cyc + 1;
   // ------
   // checks
   // ------
   task automatic chk(input logic [9:0] got, exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_n(input int got, exp, input string what);
      comparisons++;
      if (got != exp)
      begin
         num_errors++;
         $display("unexpected at %0t: %s %0d not %0d", $time, what, got, exp);
      end
   endtask : chk_n
   task automatic close_out();
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   initial
   begin
      #500000;
      num_errors++;
      close_out();
   end
   // control bits: immediate, next, above, below, self test, optical
   task automatic setup(input logic [5:0] v, input int w);
      @(negedge sys_clk);
      {load_enable_immediate, load_enable_next, mode_above_mid,
       mode_below_mid, self_test_enable_low, optical_output_disable} = v;
      repeat (w) @(negedge sys_clk);
   endtask : setup
   task automatic put(input logic s, f, input logic [7:0] d);
      c.sc = s;
      c.fv = f;
      c.data = d;
      stx_host_model_inst.send(c);
   endtask : put
   function automatic logic [9:0] byp(input stx_char_s ch);
      logic [9:0] r;
      r[9] = ch.sc;
      r[0] = ch.fv;
      for (int i = 0; i < 8; i++)
         r[8 - i] = ch.data[i];
      return r;
   endfunction : byp
   task automatic pairs();
      stx_pair_s d;
      stx_pair_s o;
      d = serial_out_pair_diag;
      o = (optical_output_disable || !(mode_above_mid | mode_below_mid))
          ? stx_pair_s'(2'h1) : d;
      chk(10'(d), {8'h00, d.p, ~d.p}, "diag");
      chk(10'(serial_out_pair_first), 10'(o), "first");
      chk(10'(serial_out_pair_second), 10'(o), "second");
   endtask : pairs
   // frames start where the counter mirror says bit a shows
   task automatic grab(input int n);
      logic [9:0] w;
      fr.delete();
      for (int k = 0; k < 10 && cyc % 10 != 1; k++)
         @(negedge sys_clk);
      repeat (n)
      begin
         for (int k = 0; k < 10; k++)
         begin
            w = {w[8:0], serial_out_pair_diag.p};
            pairs();
            lows += (read_strobe_out === 1'b0);
            @(negedge sys_clk);
         end
         fr.push_back(w);
      end
   endtask : grab
   task automatic expect_seq();
      int i;
      grab(ex.size() + 5);
      i = 0;
      while (i < 5 && fr[i] !== ex[0])
         i++;
      foreach (ex[j])
         chk(fr[i + j], ex[j], "char");
   endtask : expect_seq
   // pads alternate in disparity from frame s on
   task automatic chk_pads(input int s);
      logic [9:0] e;
      e = (fr[s] === 10'h0FA) ? 10'h0FA : 10'h305;
      for (int i = s; i < fr.size(); i++)
      begin
         chk(fr[i], e, "pad");
         e = ~e;
      end
   endtask : chk_pads
   task automatic count(input int n);
      lows = 0;
      highs = 0;
      repeat (n)
      begin
         lows += (read_strobe_out === 1'b0);
         highs += (byte_write_clock === 1'b1);
         @(negedge sys_clk);
      end
   endtask : count
   // ---------
   // scenarios
   // ---------
   task automatic t_enc();
      setup(6'h26, 25);
      stx_host_model_inst.gap = 3;
      put(1'h0, 1'h0, 8'hB5);
      put(1'h1, 1'h0, 8'hE0);
      put(1'h0, 1'h1, 8'h00);
      put(1'h1, 1'h0, 8'hB5);
      put(1'h0, 1'h0, 8'hB5);
      ex = {10'h2AA, 10'h3F0, 10'h3F0, 10'h3F0, 10'h2AA};
      expect_seq();
      stx_host_model_inst.gap = 0;
   endtask : t_enc
   task automatic t_fill();
      setup(6'h3A, 25);
      ex.delete();
      for (int i = 0; i < 17; i++)
      begin
         put(1'h1, 1'h0, 8'(i * 13 + 1)); // a high, j low
         ex.push_back(byp(c));
      end
      repeat (30) @(negedge sys_clk);
      chk(10'(wr_ready), 10'h000, "full");
      setup(6'h1A, 0);
      expect_seq();
   endtask : t_fill
   task automatic t_bist();
      int v;
      setup(6'h38, 25);
      grab(3);
      foreach (fr[k])
         chk(fr[k], 10'h2AA, "alt");
      setup(6'h28, 25);
      lows = 0;
      v = 0;
      grab(511);
      foreach (fr[k])
         v += (fr[k] === 10'h3F0);
      chk_n(lows, 6, "loop strobe");
      chk_n(int'(v > 0), 1, "loop violations");
      setup(6'h3A, 25);
      grab(4);
      chk_pads(1);
      setup(6'h1A, 0);
      put(1'h0, 1'h1, 8'h3C);
      ex = {byp(c)};
      expect_seq();
   endtask : t_bist
   task automatic t_reset();
      repeat (4) @(negedge sys_clk);
      chk({1'h0, wr_ready, read_strobe_out, byte_write_clock,
           serial_out_pair_first, serial_out_pair_second,
           serial_out_pair_diag}, 10'h195, "reset");
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
   endtask : t_reset
   task automatic t_idle();
      setup(6'h36, 25);
      grab(4);
      chk_pads(0);
   endtask : t_idle
   task automatic t_strobe();
      setup(6'h16, 25);
      count(10);
      chk_n(lows, 6, "strobe low");
      chk_n(highs, 5, "byte clock");
      setup(6'h26, 25);
      count(10);
      chk_n(lows, 0, "strobe idle");
   endtask : t_strobe
   task automatic t_optical();
      setup(6'h37, 25);
      grab(4);
      chk_pads(0);
   endtask : t_optical
   // the bench clock stands in for the tester's bit clock, running
   // well ahead of the first byte boundary after the mode change;
   // optical disable stays high so pair A/B is free as clock input
   task automatic t_test();
      setup(6'h23, 25);
      put(1'h0, 1'h0, 8'hB5);
      ex = {10'h2AA};
      expect_seq();
   endtask : t_test
   // ----
   // main
   // ----
   initial
   begin
      t_reset();
      t_idle();
      t_enc();
      t_strobe();
      t_fill();
      t_optical();
      t_test();
      t_bist();
      close_out();
   end
endmodule : serial_link_tx_8b10b_tb_top
